// [timer_channel_input_conditioning.sv]
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
// top: axi4-lite registers, two channels, output polarity and interrupt
// Function
// RQ1 - filter output changes only after N successive agreeing samples
// RQ2 - code 0000 samples at dead-time rate, one sample suffices
// RQ3 - codes 0001..0011 sample at timer clock, need 2, 4, 8
// RQ4 - codes 0100..1001 sample dts/2,/4,/8; even needs 6, odd 8
// RQ5 - codes 1010..1100 dts/16 N 5,6,8; 1101..1111 dts/32 N 5,6,8
// RQ6 - channel 1 filter 15:12, divider 11:10, mode 9:8, same behaviour
// RQ7 - capture on every 1st, 2nd, 4th or 8th selected edge
// RQ8 - edge counter cleared while channel enable is zero
// RQ9 - complementary polarity 0 active high, 1 active low
// RQ10 - polarity bits unwritable while protection level is 11 or 10
// RQ11 - complementary enable gates channel 0 complementary output
// RQ12 - primary polarity 0 active high, 1 active low
// RQ13 - input mode polarity pair selects rising, falling inverted, or both edges
// RQ14 - enable drives output active in output mode, allows capture in input
// RQ15 - channel 1 bits 7, 5, 4; bit 6 unused
// RQ16 - software writes zero to bits 15:8 and 6
// RQ17 - mode 00 output, 01 own, 10 neighbour, 11 internal trigger
// RQ18 - mode field writable only while channel enable is clear
// RQ19 - agreement counter restarts on any differing sample
module timer_channel_input_conditioning (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic chan0_input_signal,
   input wire logic chan1_input_signal,
   input wire logic internal_trigger_select,
   input wire logic [1:0] chanRef,
   output logic chan0_output_pin,
   output logic chan0CompOutPin,
   output logic chan1OutputPin,
   output logic [1:0] captureEvt,
   output logic irq
);
   logic [15:0] cfg_q, ep_q;
   logic [1:0] protection_level_q, intStat_q, intEn_q;
   logic [1:0] in0Sync_q, in1Sync_q, trgSync_q;
   logic [7:0] awAddr_q, arAddr_q;
   logic awHave_q, wHave_q, bValid_q, rValid_q, arReady_q, awReady_q, wReady_q;
   logic [31:0] wData_q, rData_q;
   logic [3:0] wStrb_q;
   logic [1:0] bResp_q, rResp_q;
   logic [$clog2(tci_pkg::DTS_CYCLES+1)-1:0] dtsCnt_q;
   logic out0_q, outN_q, out1_q, irq_q;
   logic [1:0] capt_q;

   tci_pkg::tci_chan_cfg_t cfg0, cfg1;
   logic filt0, filt1, capt0, capt1, dtsTick;
   logic doWrite, wrCfg, wrEp, wrProt, wrEn, wrClr, wrLo, wrHi, protLock, mapped, rdMapped;
   logic [15:0] cfgNext, epNext, epWr, rdWord;
   logic [1:0] modeLock;

   assign dtsTick = dtsCnt_q == '0;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) dtsCnt_q <= '0;
      else if (dtsTick) dtsCnt_q <= ($bits(dtsCnt_q))'(tci_pkg::DTS_CYCLES - 1);
      else dtsCnt_q <= dtsCnt_q - 1'b1;
   end

   // pins from outside: two flip-flops before any logic
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in0Sync_q <= 2'h0;
         in1Sync_q <= 2'h0;
         trgSync_q <= 2'h0;
      end else begin
         in0Sync_q <= {in0Sync_q[0], chan0_input_signal};
         in1Sync_q <= {in1Sync_q[0], chan1_input_signal};
         trgSync_q <= {trgSync_q[0], internal_trigger_select};
      end
   end

   assign cfg0 = '{filterSel: cfg_q[tci_pkg::CH0_FLT_POS +: 4],
      edgeDivider: cfg_q[tci_pkg::CH0_DIV_POS +: 2],
      modeSel: tci_pkg::tci_mode_t'(cfg_q[tci_pkg::CH0_MODE_POS +: 2]),
      enable: ep_q[tci_pkg::CH0_EN_POS], polarity: ep_q[tci_pkg::CH0_POL_POS],
      compPolarity: ep_q[tci_pkg::CH0_COMP_POL_POS]};
   assign cfg1 = '{filterSel: cfg_q[tci_pkg::CH1_FLT_POS +: 4], // RQ6
      edgeDivider: cfg_q[tci_pkg::CH1_DIV_POS +: 2],
      modeSel: tci_pkg::tci_mode_t'(cfg_q[tci_pkg::CH1_MODE_POS +: 2]),
      enable: ep_q[tci_pkg::CH1_EN_POS], polarity: ep_q[tci_pkg::CH1_POL_POS], // RQ15
      compPolarity: ep_q[tci_pkg::CH1_COMP_POL_POS]};

   tci_chan u_chan0 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .dtsTick(dtsTick),
      .rawIn(in0Sync_q[1]),
      .neighFilt(filt1),
      .trigIn(trgSync_q[1]),
      .cfg(cfg0),
      .filtOut(filt0),
      .capture(capt0)
   );
   tci_chan u_chan1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .dtsTick(dtsTick),
      .rawIn(in1Sync_q[1]),
      .neighFilt(filt0),
      .trigIn(trgSync_q[1]),
      .cfg(cfg1),
      .filtOut(filt1),
      .capture(capt1)
   );

   // axi write path: address and data held until both present
   assign doWrite = awHave_q && wHave_q && !bValid_q;
   assign wrCfg = doWrite && awAddr_q == tci_pkg::CHAN_CFG_OFF;
   assign wrEp = doWrite && awAddr_q == tci_pkg::CHAN_EP_OFF;
   assign wrProt = doWrite && awAddr_q == tci_pkg::PROTECTION_LEVEL_OFF;
   assign wrEn = doWrite && awAddr_q == tci_pkg::INT_EN_OFF;
   assign wrClr = doWrite && awAddr_q == tci_pkg::INT_CLR_OFF;
   assign mapped = wrCfg || wrEp || wrProt || wrEn || wrClr ||
      awAddr_q == tci_pkg::INT_STAT_OFF;
   assign wrLo = wStrb_q[0];
   assign wrHi = wStrb_q[1];
   assign protLock = protection_level_q == tci_pkg::PROTECTION_LEVEL_LOCK3 || protection_level_q == tci_pkg::PROTECTION_LEVEL_LOCK2;
   assign modeLock = {ep_q[tci_pkg::CH1_EN_POS], ep_q[tci_pkg::CH0_EN_POS]};
   // mode fields frozen while their channel is enabled
   assign cfgNext = {wrHi ? wData_q[15:10] : cfg_q[15:10],
      (wrHi && !modeLock[1]) ? wData_q[9:8] : cfg_q[9:8], // RQ18
      wrLo ? wData_q[7:2] : cfg_q[7:2],
      (wrLo && !modeLock[0]) ? wData_q[1:0] : cfg_q[1:0]}; // RQ18
   // reserved bits stay zero even if software misbehaves
   assign epWr = wData_q[15:0] & tci_pkg::CHAN_EP_WMASK; // RQ16
   assign epNext = !wrLo ? ep_q : {8'h00,
      protLock ? ep_q[7] : epWr[7], 1'b0, protLock ? ep_q[5] : epWr[5], epWr[4],
      protLock ? ep_q[3] : epWr[3], epWr[2], protLock ? ep_q[1] : epWr[1], epWr[0]}; // RQ10

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awReady_q <= 1'b1;
         wReady_q <= 1'b1;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= tci_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !awHave_q) begin
            awHave_q <= 1'b1;
            awReady_q <= 1'b0;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHave_q) begin
            wHave_q <= 1'b1;
            wReady_q <= 1'b0;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            bValid_q <= 1'b1;
            bResp_q <= mapped ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
         end else if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= tci_pkg::CHAN_CFG_RST;
         ep_q <= tci_pkg::CHAN_EP_RST;
         protection_level_q <= 2'h0;
         intEn_q <= 2'h0;
      end else begin
         if (wrCfg) cfg_q <= cfgNext;
         if (wrEp) ep_q <= epNext;
         // protection level may only be raised, as a lock should
         if (wrProt && wrLo && wData_q[1:0] > protection_level_q) protection_level_q <= wData_q[1:0];
         if (wrEn && wrLo) intEn_q <= wData_q[1:0];
      end
   end

   // sticky capture flags; a new capture wins over a clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) intStat_q <= 2'h0;
      else intStat_q <= (intStat_q & ~((wrClr && wrLo) ? wData_q[1:0] : 2'h0)) |
         {capt1, capt0};
   end

   // axi read path
   assign rdMapped = arAddr_q == tci_pkg::CHAN_CFG_OFF || arAddr_q == tci_pkg::CHAN_EP_OFF ||
      arAddr_q == tci_pkg::PROTECTION_LEVEL_OFF || arAddr_q == tci_pkg::INT_STAT_OFF ||
      arAddr_q == tci_pkg::INT_EN_OFF || arAddr_q == tci_pkg::INT_CLR_OFF;
   assign rdWord = (arAddr_q == tci_pkg::CHAN_CFG_OFF) ? cfg_q :
      (arAddr_q == tci_pkg::CHAN_EP_OFF) ? ep_q :
      (arAddr_q == tci_pkg::PROTECTION_LEVEL_OFF) ? {14'h0000, protection_level_q} :
      (arAddr_q == tci_pkg::INT_STAT_OFF) ? {14'h0000, intStat_q} :
      (arAddr_q == tci_pkg::INT_EN_OFF) ? {14'h0000, intEn_q} : 16'h0000;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arReady_q <= 1'b0;
         arAddr_q <= 8'h00;
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= tci_pkg::RESP_OKAY;
      end else begin
         arReady_q <= 1'b0;
         if (s_axi_arvalid && !arReady_q && !rValid_q) begin
            arReady_q <= 1'b1;
            arAddr_q <= s_axi_araddr;
         end
         if (arReady_q) begin
            rValid_q <= 1'b1;
            rData_q <= {16'h0000, rdWord};
            rResp_q <= rdMapped ? tci_pkg::RESP_OKAY : tci_pkg::RESP_SLVERR;
         end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
         end
      end
   end

   // outputs: polarity applied to compare reference, gated by enables
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out0_q <= 1'b0;
         outN_q <= 1'b0;
         out1_q <= 1'b0;
         capt_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         out0_q <= (cfg0.modeSel == tci_pkg::MODE_OUT && cfg0.enable) ?
            chanRef[0] ^ cfg0.polarity : 1'b0; // RQ12 RQ14
         outN_q <= (cfg0.modeSel == tci_pkg::MODE_OUT && ep_q[tci_pkg::CH0_COMP_EN_POS]) ?
            ~chanRef[0] ^ cfg0.compPolarity : 1'b0; // RQ9 RQ11
         out1_q <= (cfg1.modeSel == tci_pkg::MODE_OUT && cfg1.enable) ?
            chanRef[1] ^ cfg1.polarity : 1'b0; // RQ12 RQ14
         capt_q <= {capt1, capt0};
         irq_q <= |(intStat_q & intEn_q);
      end
   end

   // write ready flops hold the inverse of the holding flags so the pins come from a flop
   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign chan0_output_pin = out0_q;
   assign chan0CompOutPin = outN_q;
   assign chan1OutputPin = out1_q;
   assign captureEvt = capt_q;
   assign irq = irq_q;
endmodule

// [tci_pkg.sv]
// package for timer channel input conditioning: offsets, fields, reset values, types
package tci_pkg;
   localparam logic [7:0] CHAN_CFG_OFF = 8'h18;
   localparam logic [7:0] CHAN_EP_OFF = 8'h20;
   localparam logic [7:0] PROTECTION_LEVEL_OFF = 8'h44;
   localparam logic [7:0] INT_STAT_OFF = 8'h50;
   localparam logic [7:0] INT_EN_OFF = 8'h54;
   localparam logic [7:0] INT_CLR_OFF = 8'h58;
   localparam logic [15:0] CHAN_EP_RST = 16'h0000;
   localparam logic [15:0] CHAN_CFG_RST = 16'h0000;
   localparam logic [15:0] CHAN_EP_WMASK = 16'h00BF;
   localparam int CH0_FLT_POS = 4;
   localparam int CH0_DIV_POS = 2;
   localparam int CH0_MODE_POS = 0;
   localparam int CH1_FLT_POS = 12;
   localparam int CH1_DIV_POS = 10;
   localparam int CH1_MODE_POS = 8;
   localparam int CH0_EN_POS = 0;
   localparam int CH0_POL_POS = 1;
   localparam int CH0_COMP_EN_POS = 2;
   localparam int CH0_COMP_POL_POS = 3;
   localparam int CH1_EN_POS = 4;
   localparam int CH1_POL_POS = 5;
   localparam int CH1_COMP_POL_POS = 7;
   localparam logic [1:0] PROTECTION_LEVEL_LOCK2 = 2'h2;
   localparam logic [1:0] PROTECTION_LEVEL_LOCK3 = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int DTS_DIV = 1;
   localparam int DTS_CYCLES = DTS_DIV;

   typedef enum logic [1:0] {
      MODE_OUT = 2'b00,
      MODE_IN_OWN = 2'b01,
      MODE_IN_NEIGH = 2'b10,
      MODE_IN_TRIG = 2'b11
   } tci_mode_t;

   typedef struct packed {
      logic [3:0] filterSel;
      logic [1:0] edgeDivider;
      tci_mode_t modeSel;
      logic enable;
      logic polarity;
      logic compPolarity;
   } tci_chan_cfg_t;
endpackage

// [tci_chan.sv]
`timescale 1ns/1ps
// one channel: filter, edge select, capture prescaler
module tci_chan (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic dtsTick,
   input wire logic rawIn,
   input wire logic neighFilt,
   input wire logic trigIn,
   input wire tci_pkg::tci_chan_cfg_t cfg,
   output logic filtOut,
   output logic capture
);
   logic [4:0] divCnt_q;
   logic [2:0] runCnt_q;
   logic filt_q, sel_q, capt_q;
   logic [2:0] edgeCnt_q;
   logic sampleTick, useKernel;
   logic [4:0] divMask;
   logic [3:0] nNeed;
   logic differs, qualified, selIn, selSrc, rise, fall, evt, divDone;
   logic [2:0] edgeMax;

   assign useKernel = (cfg.filterSel == 4'h1) || (cfg.filterSel == 4'h2) ||
      (cfg.filterSel == 4'h3); // RQ3
   always_comb begin
      unique case (cfg.filterSel)
         4'h0: begin divMask = 5'h00; nNeed = 4'h1; end // RQ2
         4'h1: begin divMask = 5'h00; nNeed = 4'h2; end // RQ3
         4'h2: begin divMask = 5'h00; nNeed = 4'h4; end
         4'h3: begin divMask = 5'h00; nNeed = 4'h8; end
         4'h4: begin divMask = 5'h01; nNeed = 4'h6; end // RQ4
         4'h5: begin divMask = 5'h01; nNeed = 4'h8; end
         4'h6: begin divMask = 5'h03; nNeed = 4'h6; end
         4'h7: begin divMask = 5'h03; nNeed = 4'h8; end
         4'h8: begin divMask = 5'h07; nNeed = 4'h6; end
         4'h9: begin divMask = 5'h07; nNeed = 4'h8; end
         4'hA: begin divMask = 5'h0F; nNeed = 4'h5; end // RQ5
         4'hB: begin divMask = 5'h0F; nNeed = 4'h6; end
         4'hC: begin divMask = 5'h0F; nNeed = 4'h8; end
         4'hD: begin divMask = 5'h1F; nNeed = 4'h5; end
         4'hE: begin divMask = 5'h1F; nNeed = 4'h6; end
         4'hF: begin divMask = 5'h1F; nNeed = 4'h8; end
      endcase
   end
   assign sampleTick = useKernel || (dtsTick && ((divCnt_q & divMask) == 5'h00));
   assign differs = rawIn != filt_q;
   // run counter holds samples seen minus one
   assign qualified = sampleTick && differs && ({1'b0, runCnt_q} == nNeed - 4'h1); // RQ1
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= 5'h00;
         runCnt_q <= 3'h0;
         filt_q <= 1'b0;
      end else begin
         if (dtsTick) divCnt_q <= divCnt_q + 5'h01;
         if (sampleTick) begin
            if (!differs || qualified) runCnt_q <= 3'h0; // RQ19
            else runCnt_q <= runCnt_q + 3'h1;
            if (qualified) filt_q <= rawIn; // RQ1
         end
      end
   end
   assign filtOut = filt_q;

   assign selSrc = (cfg.modeSel == tci_pkg::MODE_IN_NEIGH) ? neighFilt :
      (cfg.modeSel == tci_pkg::MODE_IN_TRIG) ? trigIn : filt_q; // RQ17
   // inversion only for falling-edge select; reserved code treated as rising
   assign selIn = selSrc ^ (cfg.polarity & ~cfg.compPolarity); // RQ13
   assign rise = selIn && !sel_q;
   assign fall = !selIn && sel_q;
   assign evt = (cfg.modeSel != tci_pkg::MODE_OUT) && cfg.enable &&
      (rise || (cfg.polarity && cfg.compPolarity && fall)); // RQ13 RQ14
   assign edgeMax = (cfg.edgeDivider == 2'h0) ? 3'h0 : (cfg.edgeDivider == 2'h1) ? 3'h1 :
      (cfg.edgeDivider == 2'h2) ? 3'h3 : 3'h7;
   assign divDone = edgeCnt_q == edgeMax; // RQ7
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= 1'b0;
         edgeCnt_q <= 3'h0;
         capt_q <= 1'b0;
      end else begin
         sel_q <= selIn;
         capt_q <= evt && divDone;
         if (!cfg.enable) edgeCnt_q <= 3'h0; // RQ8
         else if (evt) edgeCnt_q <= divDone ? 3'h0 : edgeCnt_q + 3'h1; // RQ7
      end
   end
   assign capture = capt_q;
endmodule

// [tci_props.sv]
`timescale 1ns/1ps
// checker on the top ports: bus answers, output pins, interrupt line
module tci_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] chanRef,
   input wire logic chan0CompOutPin,
   input wire logic chan1OutputPin,
   input wire logic [1:0] captureEvt,
   input wire logic irq
);
   logic [7:0] rdAddr_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // remembers which register the pending read answers for
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) rdAddr_q <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
   end

   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a registered pin may only move after a register write or a reference change
   sequence cause(r);
      $past(s_axi_bvalid) || ($past(r) != $past(r, 2));
   endsequence

   out_pin_cause_a: assert property ($changed(chan1OutputPin) |-> cause(chanRef[1]))
      else $error("channel 1 pin moved without cause");
   comp_pin_cause_a: assert property ($changed(chan0CompOutPin) |-> cause(chanRef[0]))
      else $error("complementary pin moved without cause");
   irq_rise_a: assert property ($rose(irq) |-> $past(|captureEvt) || $past(s_axi_bvalid))
      else $error("interrupt rose without capture or write");
   irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
      else $error("interrupt fell without write");
   ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read address ready longer than one cycle");
   read_latency_a: assert property (rdTaken |=> s_axi_rvalid)
      else $error("read data late");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp == tci_pkg::RESP_SLVERR
      |-> s_axi_rdata == 32'h00000000) else $error("error read carries data");
   reserved_zero_a: assert property (s_axi_rvalid && rdAddr_q == tci_pkg::CHAN_EP_OFF
      |-> (s_axi_rdata & 32'hFFFFFF40) == 32'h00000000) else $error("reserved bits set");
endmodule

// [tci_pin_model.sv]
`timescale 1ns/1ps
// pin model: drives the channel 0 input pin with timed pulses, holds channel 1 low
module tci_pin_model (
   input wire logic sys_clk,
   output logic chan0_input_signal,
   output logic chan1_input_signal
);
   initial begin
      chan0_input_signal = 1'b0;
      chan1_input_signal = 1'b0;
   end

   // n pulses, hi clocks high then lo clocks low; call just after an edge
   task automatic pulse(input int hi, input int lo, input int n);
      repeat (n) begin
         chan0_input_signal <= 1'b1;
         repeat (hi) @(posedge sys_clk);
         chan0_input_signal <= 1'b0;
         repeat (lo) @(posedge sys_clk);
      end
   endtask
endmodule

// [timer_channel_input_conditioning_test.sv]
`timescale 1ns/1ps
// self-checking bench for the timer channel input conditioning block
module timer_channel_input_conditioning_test;
   logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, chan0_input_signal, chan1_input_signal, internal_trigger_select;
   logic chan0_output_pin, chan0CompOutPin, chan1OutputPin, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, chanRef, captureEvt, lastB;
   int err_count, checks, capCount, capCount1;

   timer_channel_input_conditioning dut (
      .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan0_input_signal,
      .chan1_input_signal, .internal_trigger_select, .chanRef, .chan0_output_pin,
      .chan0CompOutPin, .chan1OutputPin, .captureEvt, .irq
   );
   tci_pin_model pins (.sys_clk, .chan0_input_signal, .chan1_input_signal);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (captureEvt[0] === 1'b1) capCount++;
      if (captureEvt[1] === 1'b1) capCount1++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      lastB = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(tci_pkg::RESP_OKAY));
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rc(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      rc(tci_pkg::CHAN_CFG_OFF, 32'h00000000);
      rd(8'h3C, d, r);
      chk(32'(r), 32'(tci_pkg::RESP_SLVERR));
      wr(8'h3C, 32'h0000FFFF);
      chk(32'(lastB), 32'(tci_pkg::RESP_SLVERR));
      wr(tci_pkg::CHAN_EP_OFF, 32'h0000FFFF);
      rc(tci_pkg::CHAN_EP_OFF, 32'h000000BF);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h00000303);
      rc(tci_pkg::CHAN_CFG_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h0000F231);
      rc(tci_pkg::CHAN_CFG_OFF, 32'h0000F231);
   endtask

   task automatic t_filter();
      wr(tci_pkg::INT_EN_OFF, 32'h00000001);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000001);
      capCount = 0;
      pins.pulse(7, 20, 1);
      pins.pulse(5, 1, 1);
      pins.pulse(5, 20, 1);
      chk(32'(capCount), 32'h00000000);
      pins.pulse(8, 20, 1);
      chk(32'(capCount), 32'h00000001);
      chk(32'(irq), 32'h00000001);
      rc(tci_pkg::INT_STAT_OFF, 32'h00000001);
      wr(tci_pkg::INT_CLR_OFF, 32'h00000001);
      @(posedge sys_clk);
      chk(32'(irq), 32'h00000000);
      rc(tci_pkg::INT_STAT_OFF, 32'h00000000);
   endtask

   task automatic t_divider();
      int ep [3] = '{1, 3, 11};
      int ex [3] = '{2, 2, 4};
      wr(tci_pkg::INT_EN_OFF, 32'h00000000);
      for (int k = 0; k < 4; k++) begin
         wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
         wr(tci_pkg::CHAN_CFG_OFF, 32'((k << 2) + 1));
         wr(tci_pkg::CHAN_EP_OFF, 32'h00000001);
         capCount = 0;
         pins.pulse(3, 3, 8);
         repeat (10) @(posedge sys_clk);
         chk(32'(capCount), 32'(8 >> k));
      end
      capCount = 0;
      pins.pulse(3, 3, 4);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000001);
      pins.pulse(3, 3, 4);
      repeat (10) @(posedge sys_clk);
      chk(32'(capCount), 32'h00000000);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h00000001);
      for (int j = 0; j < 3; j++) begin
         // polarity set while disabled so the inversion step is not seen as an edge
         wr(tci_pkg::CHAN_EP_OFF, 32'(ep[j] - 1));
         wr(tci_pkg::CHAN_EP_OFF, 32'(ep[j]));
         capCount = 0;
         pins.pulse(3, 3, 2);
         repeat (10) @(posedge sys_clk);
         chk(32'(capCount), 32'(ex[j]));
      end
      chk(32'(irq), 32'h00000000);
      rc(tci_pkg::INT_STAT_OFF, 32'h00000001);
   endtask

   task automatic t_outputs();
      logic v;
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h00000000);
      chanRef <= 2'b11;
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000010);
      repeat (2) @(posedge sys_clk);
      chk(32'(chan1OutputPin), 32'h00000001);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000030);
      repeat (2) @(posedge sys_clk);
      chk(32'(chan1OutputPin), 32'h00000000);
      chanRef <= 2'b01;
      repeat (2) @(posedge sys_clk);
      chk(32'(chan1OutputPin), 32'h00000001);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000005);
      repeat (2) @(posedge sys_clk);
      chk(32'(chan0_output_pin), 32'h00000001);
      v = chan0CompOutPin;
      wr(tci_pkg::CHAN_EP_OFF, 32'h0000000D);
      repeat (2) @(posedge sys_clk);
      chk(32'(v ^ chan0CompOutPin), 32'h00000001);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000001);
      repeat (2) @(posedge sys_clk);
      chk(32'(chan0CompOutPin), 32'h00000000);
   endtask

   // sampled filters on ch0, ch1 fed from its neighbour, then from the trigger
   task automatic t_modes();
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h00000241);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000011);
      capCount = 0;
      capCount1 = 0;
      pins.pulse(10, 30, 1);
      chk(32'(capCount), 32'h00000000);
      pins.pulse(13, 30, 1);
      chk(32'(capCount), 32'h00000001);
      chk(32'(capCount1), 32'h00000001);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000000);
      wr(tci_pkg::CHAN_CFG_OFF, 32'h000003A1);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000011);
      capCount = 0;
      capCount1 = 0;
      pins.pulse(63, 40, 1);
      chk(32'(capCount), 32'h00000000);
      pins.pulse(81, 100, 1);
      chk(32'(capCount), 32'h00000001);
      repeat (2) begin
         internal_trigger_select <= 1'b1;
         repeat (4) @(posedge sys_clk);
         internal_trigger_select <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      chk(32'(capCount1), 32'h00000002);
   endtask

   // protection only rises until reset, so this runs last
   task automatic t_protect();
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000020);
      wr(tci_pkg::PROTECTION_LEVEL_OFF, 32'h00000002);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000010);
      rc(tci_pkg::CHAN_EP_OFF, 32'h00000030);
      wr(tci_pkg::PROTECTION_LEVEL_OFF, 32'h00000003);
      wr(tci_pkg::CHAN_EP_OFF, 32'h00000080);
      rc(tci_pkg::CHAN_EP_OFF, 32'h00000020);
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
      {s_axi_rready, internal_trigger_select, chanRef} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h000000000000;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_filter();
      t_divider();
      t_outputs();
      t_modes();
      t_protect();
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      report_and_stop();
   end
endmodule

bind timer_channel_input_conditioning tci_props u_props (
   .sys_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .chanRef, .chan0CompOutPin,
   .chan1OutputPin, .captureEvt, .irq
);
